// file: port_cfg_defines.vh
// offsets, reset values and field positions for the port configuration block
`ifndef PORT_CFG_DEFINES_VH
`define PORT_CFG_DEFINES_VH
// port_pin_mode_select offsets (ports e, f, g)
`define OFS_MODE_E      8'h00
`define OFS_MODE_F      8'h01
`define OFS_MODE_G      8'h02
// port_pin_direction offsets, ports a..g
`define OFS_DIR_A       8'h04
`define OFS_DIR_B       8'h05
`define OFS_DIR_C       8'h06
`define OFS_DIR_D       8'h07
`define OFS_DIR_E       8'h08
`define OFS_DIR_F       8'h09
`define OFS_DIR_G       8'h0a
// port_pin_driver_select offsets, ports a..g
`define OFS_DRV_A       8'h0c
`define OFS_DRV_B       8'h0d
`define OFS_DRV_C       8'h0e
`define OFS_DRV_D       8'h0f
`define OFS_DRV_E       8'h10
`define OFS_DRV_F       8'h11
`define OFS_DRV_G       8'h12
// memory_mode_register offset and peripheral buffer enable bit
`define OFS_MEM_MODE    8'h14
`define MEM_MODE_PIO    7
// reset value and port d write mask
`define CFG_RESET       8'h00
`define D_PORT_MASK     8'h0f
// boot pattern is board specific; keep the two halves in step with it
`define BOOT_PATTERN    16'h5aa5
`define BOOT_PATTERN_LO 8'ha5
`define BOOT_PATTERN_HI 8'h5a
`endif

// file: pin_sync.v
// three-flop input synchroniser, change taken when second and third agree
module pin_sync (
    // clock and reset
    input  wire       clock,
    input  wire       nrst,
    // pins and result
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out
);
    reg [7:0] s1_r;
    reg [7:0] s2_r;
    reg [7:0] s3_r;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r    <= 8'h00;
            s2_r    <= 8'h00;
            s3_r    <= 8'h00;
            pin_out <= 8'h00;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // accept per bit only when stable over two samples
            pin_out <= (s2_r & s3_r) | (pin_out & (s2_r | s3_r));
        end
    end
endmodule // pin_sync

// file: pin_driver.v
// per-pin driver: direction, open drain and slew per port
module pin_driver (
    // clock and reset
    input  wire       clock,
    input  wire       nrst,
    // control
    input  wire [7:0] out_data,
    input  wire [7:0] dir_bits,
    input  wire [7:0] oe_term,
    input  wire [7:0] drv_bits,
    input  wire       drv_is_od,
    input  wire       force_off,
    // pins, enables active low
    output reg  [7:0] pin_o,
    output reg  [7:0] pin_oe_n,
    output reg  [7:0] fast_slew
);
    wire [7:0] want;
    assign want = (dir_bits | oe_term) & {8{~force_off}};
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    pin_o[i]     <= 1'b0;
                    pin_oe_n[i]  <= 1'b1;
                    fast_slew[i] <= 1'b0;
                end else begin
                    pin_o[i] <= out_data[i];
                    // open drain only pulls low; high is released
                    if (drv_is_od && drv_bits[i])
                        pin_oe_n[i] <= ~(want[i] & ~out_data[i]);
                    else
                        pin_oe_n[i] <= ~want[i];
                    fast_slew[i] <= ~drv_is_od & drv_bits[i];
                end
            end
        end
    endgenerate
endmodule // pin_driver

// file: port_config.v
// port mode and configuration logic for seven host ports
`include "port_cfg_defines.vh"
module port_config (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // host register access at offsets from io_register_base
    input  wire        reg_sel,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // static configuration
    input  wire        data_port_en,
    input  wire        host_reset_mode_en,
    input  wire        jtag_en,
    // host bus status
    input  wire        host_reset_n,
    input  wire        bus_cycle,
    input  wire        host_address_strobe,
    input  wire [15:0] host_data_out,
    input  wire        host_data_wr,
    // logic array terms
    input  wire [55:0] oe_terms,
    input  wire [55:0] out_data,
    input  wire [55:0] addr_out,
    input  wire [39:0] addr_in_sel,
    input  wire        peripheral_select_term_a,
    input  wire        peripheral_select_term_b,
    // pins, seven ports of eight
    input  wire [55:0] pin_i,
    output wire [55:0] pin_o,
    output wire [55:0] pin_oe_n,
    output wire [55:0] fast_slew,
    // to logic arrays and host
    output reg  [55:0] array_in,
    output reg  [39:0] addr_in,
    output reg  [39:0] addr_captured,
    output reg  [15:0] host_data_in,
    output reg         jtag_active
);
    reg  [7:0]  mode_r [0:2];
    reg  [7:0]  dir_r  [0:6];
    reg  [7:0]  drv_r  [0:6];
    reg  [7:0]  mem_mode_r;
    wire [55:0] pin_s;
    wire [55:0] drv_data;
    wire [55:0] drv_oe;
    wire [6:0]  force_off;
    wire        pio_on;
    wire        psel;
    wire        boot_drive;
    wire        bus_drive;
    integer     k;

    // data port owns port f, so buffer mode yields to it
    assign pio_on = mem_mode_r[`MEM_MODE_PIO] & ~data_port_en;
    assign psel   = peripheral_select_term_a | peripheral_select_term_b;
    // boot pattern only in reset, off the bus; gone once reset ends
    assign boot_drive = host_reset_mode_en & ~host_reset_n &
                        ~bus_cycle;
    assign bus_drive  = data_port_en & host_data_wr;

    // register writes; d keeps only its low nibble
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (k = 0; k < 7; k = k + 1) begin
                dir_r[k] <= `CFG_RESET;
                drv_r[k] <= `CFG_RESET;
            end
            for (k = 0; k < 3; k = k + 1)
                mode_r[k] <= `CFG_RESET;
            mem_mode_r <= `CFG_RESET;
        end else if (reg_sel && reg_wr) begin
            case (reg_addr)
                `OFS_MODE_E: mode_r[0] <= reg_wdata;
                `OFS_MODE_F: mode_r[1] <= reg_wdata;
                `OFS_MODE_G: mode_r[2] <= reg_wdata;
                `OFS_DIR_A:  dir_r[0]  <= reg_wdata;
                `OFS_DIR_B:  dir_r[1]  <= reg_wdata;
                `OFS_DIR_C:  dir_r[2]  <= reg_wdata;
                `OFS_DIR_D:  dir_r[3]  <= reg_wdata & `D_PORT_MASK;
                `OFS_DIR_E:  dir_r[4]  <= reg_wdata;
                `OFS_DIR_F:  dir_r[5]  <= reg_wdata;
                `OFS_DIR_G:  dir_r[6]  <= reg_wdata;
                `OFS_DRV_A:  drv_r[0]  <= reg_wdata;
                `OFS_DRV_B:  drv_r[1]  <= reg_wdata;
                `OFS_DRV_C:  drv_r[2]  <= reg_wdata;
                `OFS_DRV_D:  drv_r[3]  <= reg_wdata & `D_PORT_MASK;
                `OFS_DRV_E:  drv_r[4]  <= reg_wdata;
                `OFS_DRV_F:  drv_r[5]  <= reg_wdata;
                `OFS_DRV_G:  drv_r[6]  <= reg_wdata;
                `OFS_MEM_MODE: mem_mode_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // register reads, unmapped offsets read zero
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_sel && reg_rd) begin
            case (reg_addr)
                `OFS_MODE_E: reg_rdata <= mode_r[0];
                `OFS_MODE_F: reg_rdata <= mode_r[1];
                `OFS_MODE_G: reg_rdata <= mode_r[2];
                `OFS_DIR_A:  reg_rdata <= dir_r[0];
                `OFS_DIR_B:  reg_rdata <= dir_r[1];
                `OFS_DIR_C:  reg_rdata <= dir_r[2];
                `OFS_DIR_D:  reg_rdata <= dir_r[3];
                `OFS_DIR_E:  reg_rdata <= dir_r[4];
                `OFS_DIR_F:  reg_rdata <= dir_r[5];
                `OFS_DIR_G:  reg_rdata <= dir_r[6];
                `OFS_DRV_A:  reg_rdata <= drv_r[0];
                `OFS_DRV_B:  reg_rdata <= drv_r[1];
                `OFS_DRV_C:  reg_rdata <= drv_r[2];
                `OFS_DRV_D:  reg_rdata <= drv_r[3];
                `OFS_DRV_E:  reg_rdata <= drv_r[4];
                `OFS_DRV_F:  reg_rdata <= drv_r[5];
                `OFS_DRV_G:  reg_rdata <= drv_r[6];
                `OFS_MEM_MODE: reg_rdata <= mem_mode_r;
                default:     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // per-port data and enable selection
    // a,b,c: host i/o only, no mode register
    assign drv_data[23:0] = out_data[23:0];
    assign drv_oe[23:0]   = oe_terms[23:0];
    // d: no oe term, direction alone
    assign drv_data[31:24] = out_data[31:24];
    assign drv_oe[31:24]   = 8'h00;
    // e: address out where mode bit set; shared with jtag pins
    assign drv_data[39:32] = (mode_r[0] & addr_out[39:32]) |
                             (~mode_r[0] & out_data[39:32]);
    assign drv_oe[39:32]   = 8'h00;
    // f: peripheral buffer, data low byte, boot pattern or port
    assign drv_data[47:40] = boot_drive ? `BOOT_PATTERN_LO :
                             pio_on ? host_data_out[7:0] :
                             data_port_en ? host_data_out[7:0] :
                             ((mode_r[1] & addr_out[47:40]) |
                              (~mode_r[1] & out_data[47:40]));
    assign drv_oe[47:40]   = boot_drive ? 8'hff :
                             pio_on ? {8{psel & host_data_wr}} :
                             data_port_en ? {8{bus_drive}} :
                             oe_terms[47:40];
    // g: data high byte, boot pattern or port
    assign drv_data[55:48] = boot_drive ? `BOOT_PATTERN_HI :
                             data_port_en ? host_data_out[15:8] :
                             ((mode_r[2] & addr_out[55:48]) |
                              (~mode_r[2] & out_data[55:48]));
    assign drv_oe[55:48]   = (boot_drive | bus_drive) ?
                             8'hff : 8'h00;
    // direction register is ignored on ports taken over by bus logic
    assign force_off = {data_port_en | boot_drive,
                        data_port_en | boot_drive | pio_on,
                        5'b00000};

    genvar p;
    generate
        for (p = 0; p < 7; p = p + 1) begin : g_port
            pin_sync u_sync (
                .clock   (clock),
                .nrst    (nrst),
                .pin_in  (pin_i[8*p+7:8*p]),
                .pin_out (pin_s[8*p+7:8*p])
            );
            pin_driver u_drv (
                .clock     (clock),
                .nrst      (nrst),
                .out_data  (drv_data[8*p+7:8*p]),
                .dir_bits  (force_off[p] ? 8'h00 : dir_r[p]),
                .oe_term   (drv_oe[8*p+7:8*p]),
                // bus data needs both levels, so no open drain on port g while bus logic owns it
                .drv_bits  ((force_off[p] && (p == 6)) ? 8'h00 :
                            drv_r[p]),
                .drv_is_od ((p != 2) && (p != 5)),
                .force_off (1'b0),
                .pin_o     (pin_o[8*p+7:8*p]),
                .pin_oe_n  (pin_oe_n[8*p+7:8*p]),
                .fast_slew (fast_slew[8*p+7:8*p])
            );
        end
    endgenerate

    // inputs toward arrays, address capture and host data
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            array_in      <= 56'h0;
            addr_in       <= 40'h0;
            addr_captured <= 40'h0;
            host_data_in  <= 16'h0000;
            jtag_active   <= 1'b0;
        end else begin
            // general i/o inputs masked while upper ports are data bus
            array_in <= {pin_s[55:40] & {16{~data_port_en}},
                         pin_s[39:0]};
            // a..d and f feed the decoder as address inputs
            addr_in <= {pin_s[47:40], pin_s[31:0]} & addr_in_sel;
            if (host_address_strobe)
                addr_captured <= {pin_s[47:40], pin_s[31:0]} &
                                 addr_in_sel;
            host_data_in <= pio_on ? {8'h00, pin_s[47:40]} :
                            {pin_s[55:48], pin_s[47:40]};
            jtag_active  <= jtag_en;
        end
    end
endmodule // port_config

// file: port_config_sva.sv
// assertion checker for the port configuration block
`include "port_cfg_defines.vh"
module port_config_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // register access
    input wire logic        reg_sel,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // configuration and host status
    input wire logic        data_port_en,
    input wire logic        host_reset_mode_en,
    input wire logic        jtag_en,
    input wire logic        host_reset_n,
    input wire logic        bus_cycle,
    input wire logic [15:0] host_data_out,
    input wire logic        host_data_wr,
    input wire logic [55:0] oe_terms,
    input wire logic        peripheral_select_term_a,
    input wire logic        peripheral_select_term_b,
    // pins and status
    input wire logic [55:0] pin_o,
    input wire logic [55:0] pin_oe_n,
    input wire logic [55:0] fast_slew,
    input wire logic        jtag_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // shadow of the buffer enable bit, same lag as the real register
    logic pio_r;
    wire  sel_any = peripheral_select_term_a || peripheral_select_term_b;
    wire  wr_go = reg_sel && reg_wr;
    wire  periph = pio_r && !data_port_en && !host_reset_mode_en;
    always @(posedge clock or negedge nrst)
        if (!nrst)
            pio_r <= 1'b0;
        else if (wr_go && reg_addr == `OFS_MEM_MODE)
            pio_r <= reg_wdata[`MEM_MODE_PIO];
    a_rdata_idle: assert property (
        !(reg_sel && reg_rd) |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_dir_or_term: assert property (
        wr_go && reg_addr == `OFS_DIR_C |-> ##2 pin_oe_n[23:16] ==
        ~($past(reg_wdata, 2) | $past(oe_terms[23:16])))
        else $error("port c enables do not follow direction or term");
    a_slew_follow: assert property (
        wr_go && reg_addr == `OFS_DRV_C |->
        ##2 fast_slew[23:16] == $past(reg_wdata, 2))
        else $error("port c slew does not follow drive select");
    a_slew_only_cf: assert property (
        fast_slew[15:0] == 16'h0000 && fast_slew[39:24] == 16'h0000 &&
        fast_slew[55:48] == 8'h00)
        else $error("fast slew on a port without slew control");
    a_boot_drive: assert property (
        host_reset_mode_en && !host_reset_n && !bus_cycle |=>
        pin_oe_n[55:40] == 16'h0000 && pin_o[55:40] == `BOOT_PATTERN)
        else $error("boot pattern not driven during host reset");
    a_data_release: assert property (
        host_reset_n && data_port_en && !host_data_wr |=>
        pin_oe_n[55:40] == 16'hffff)
        else $error("data port driving while host reads");
    a_data_drive: assert property (
        host_reset_n && data_port_en && host_data_wr |=>
        pin_oe_n[55:40] == 16'h0000 && pin_o[55:40] == $past(host_data_out))
        else $error("data port not carrying host data");
    a_buffer_off: assert property (
        periph && !sel_any |=> pin_oe_n[47:40] == 8'hff)
        else $error("peripheral buffer driving while deselected");
    a_buffer_drive: assert property (
        periph && sel_any && host_data_wr |=> pin_oe_n[47:40] == 8'h00 &&
        pin_o[47:40] == $past(host_data_out[7:0]))
        else $error("peripheral buffer not passing host data");
    a_prog_share: assert property (jtag_en |=> jtag_active)
        else $error("programming port not enabled");
    c_buffer: cover property (periph && sel_any && host_data_wr);
    c_boot: cover property (host_reset_mode_en && !host_reset_n && !bus_cycle);
    c_dir: cover property (wr_go && reg_addr == `OFS_DIR_C);
endmodule // port_config_sva
bind port_config port_config_sva chk (.clock, .nrst, .reg_sel, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .data_port_en,
    .host_reset_mode_en, .jtag_en, .host_reset_n, .bus_cycle, .host_data_out,
    .host_data_wr, .oe_terms, .peripheral_select_term_a,
    .peripheral_select_term_b, .pin_o, .pin_oe_n, .fast_slew, .jtag_active);

// file: pin_side_model.sv
// far side model: pulled-up pins and host boot sampling
module pin_side_model (
    // host reset and pins
    input  wire logic        host_reset_n,
    input  wire logic [55:0] pin_o,
    input  wire logic [55:0] pin_oe_n,
    output logic      [55:0] pin_level,
    output logic      [15:0] boot_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // released pins sit at the pull-up, open drain needs it
    assign pin_level = pin_oe_n | pin_o;
    always @(posedge host_reset_n)
        boot_seen <= pin_level[55:40];
endmodule // pin_side_model

// file: test_port_config.sv
// self-checking bench for the port configuration block
`include "port_cfg_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_port_config;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0, nrst = 1'b0;
    logic        reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, d;
    logic        data_port_en = 1'b0, host_reset_mode_en = 1'b0;
    logic        jtag_en = 1'b0, host_reset_n = 1'b1, bus_cycle = 1'b0;
    logic        host_address_strobe = 1'b0, host_data_wr = 1'b0;
    logic        psel_a = 1'b0, psel_b = 1'b0;
    logic [15:0] host_data_out = 16'h0000;
    logic [55:0] oe_terms = 56'h0, out_data = 56'h0, addr_out = 56'h0;
    logic [39:0] addr_in_sel = 40'h0;
    logic [159:0] rnd;
    wire  [55:0] pin_i, pin_o, pin_oe_n, fast_slew, array_in;
    wire  [39:0] addr_in, addr_captured;
    wire  [15:0] host_data_in, boot_seen;
    wire  [7:0]  reg_rdata;
    wire         jtag_active;
    logic [7:0]  shadow [0:255];
    int          err_total = 0, comparisons = 0;
    always #5 clock = ~clock;
    // background traffic on the array and strobe inputs
    always @(negedge clock) begin
        // address inputs only where selected; strobe copies them
        if (nrst) begin
            `CHK(addr_in & ~addr_in_sel, 40'h0)
            if (host_address_strobe)
                `CHK(addr_captured, addr_in)
        end
        rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
        {host_address_strobe, out_data, addr_out, addr_in_sel} <= rnd[152:0];
    end
    port_config dut (.clock, .nrst, .reg_sel, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .data_port_en, .host_reset_mode_en, .jtag_en,
        .host_reset_n, .bus_cycle, .host_address_strobe, .host_data_out,
        .host_data_wr, .oe_terms, .out_data, .addr_out, .addr_in_sel,
        .peripheral_select_term_a(psel_a), .peripheral_select_term_b(psel_b),
        .pin_i, .pin_o, .pin_oe_n, .fast_slew, .array_in, .addr_in,
        .addr_captured, .host_data_in, .jtag_active);
    pin_side_model model (.host_reset_n, .pin_o, .pin_oe_n,
        .pin_level(pin_i), .boot_seen);
    function automatic bit mapped(input logic [7:0] a);
        return a <= 8'h02 || (a >= 8'h04 && a <= 8'h0a) ||
            (a >= 8'h0c && a <= 8'h12) || a == `OFS_MEM_MODE;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, v};
        // port d has four pins, upper bits never stick
        if (mapped(a))
            shadow[a] = v & ((a == `OFS_DIR_D || a == `OFS_DRV_D) ?
                `D_PORT_MASK : 8'hff);
        @(negedge clock);
        {reg_sel, reg_wr} = 2'b00;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(negedge clock);
        {reg_sel, reg_rd, reg_addr} = {2'b11, a};
        @(negedge clock);
        {reg_sel, reg_rd} = 2'b00;
        `CHK(reg_rdata, shadow[a])
    endtask
    task automatic conclude();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        for (int i = 0; i < 256; i++)
            shadow[i] = 8'h00;
        void'($urandom(81));
        repeat (3) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        `CHK(pin_oe_n, ~56'h0)
        for (int a = 0; a < 24; a++)
            rd_chk(a[7:0]);
        for (int a = 0; a < 24; a++)
            wr(a[7:0], $urandom);
        for (int a = 0; a < 24; a++)
            rd_chk(a[7:0]);
        wr(`OFS_DRV_D, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            oe_terms[23:16] = $urandom;
            wr(`OFS_DIR_C, d);
            wr(`OFS_DIR_D, d);
            wr(`OFS_DRV_C, ~d);
            repeat (2) @(negedge clock);
            `CHK(pin_oe_n[23:16], ~(d | oe_terms[23:16]))
            `CHK(pin_oe_n[27:24], ~d[3:0])
            `CHK(fast_slew[23:16], ~d)
        end
        // open drain on port a: enable follows the data, high is released
        wr(`OFS_DRV_A, 8'hff);
        wr(`OFS_DIR_A, 8'hff);
        repeat (2) @(negedge clock);
        `CHK(pin_oe_n[7:0], out_data[7:0])
        wr(`OFS_MODE_E, 8'hff);
        repeat (2) @(negedge clock);
        `CHK(pin_o[39:32], addr_out[39:32])
        wr(`OFS_MODE_E, 8'h00);
        repeat (2) @(negedge clock);
        `CHK(pin_o[39:32], out_data[39:32])
        {host_reset_mode_en, data_port_en, host_reset_n} = 3'b110;
        repeat (3) @(negedge clock);
        `CHK(pin_o[55:40], `BOOT_PATTERN)
        `CHK(pin_oe_n[55:40], 16'h0000)
        bus_cycle = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(pin_oe_n[55:40], 16'hffff)
        bus_cycle = 1'b0;
        repeat (2) @(negedge clock);
        host_reset_n = 1'b1;
        #1 `CHK(boot_seen, `BOOT_PATTERN)
        bus_cycle = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(pin_oe_n[55:40], 16'hffff)
        {host_data_wr, host_data_out} = {1'b1, 16'($urandom)};
        repeat (8) @(negedge clock);
        `CHK(pin_o[55:40], host_data_out)
        `CHK(pin_oe_n[55:40], 16'h0000)
        `CHK(host_data_in, host_data_out)
        `CHK(array_in[55:40], 16'h0000)
        {host_reset_mode_en, data_port_en, bus_cycle} = 3'b000;
        wr(`OFS_MEM_MODE, 8'h80);
        repeat (2) @(negedge clock);
        `CHK(pin_oe_n[47:40], 8'hff)
        for (int s = 1; s < 3; s++) begin
            {psel_b, psel_a, host_data_out} = {s[1:0], 16'($urandom)};
            repeat (8) @(negedge clock);
            `CHK(pin_o[47:40], host_data_out[7:0])
            `CHK(pin_oe_n[47:40], 8'h00)
            `CHK(host_data_in, 16'(host_data_out[7:0]))
        end
        jtag_en = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(jtag_active, 1'b1)
        conclude();
    end
endmodule // test_port_config
